// ===== dcf_ctrl1.sv
// First control function register with update transfer and parallel word path.
// Assumes pins arrive asynchronously; clk_in is the sync clock.
//
// What this block does
// - Decode 28 serial, 112 parallel byte addresses
// - Writes buffered until update or profile change
// - Bit 24 rising starts PLL calibration
// - Stream off: parallel word taken on update
// - Stream on: parallel word taken every edge the buffer has room
// - Bit 16 picks sine or cosine, resets 1
// - Bit 15 reloads ramp rate on update while ramp_enable_in is high
// - Bit 14 pulses ramp accumulator reset once
// - Bit 13 clears phase accumulator on update
// - Bit 12 holds ramp accumulator in reset
// - Bit 11 holds phase accumulator cleared
// - Bits 15 to 11 reset to zero
`timescale 1ns/1ns
`default_nettype none
module dcf_ctrl1 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [dcf_pkg::DCF_ADDR_W-1:0] prog_addr_in,
  input wire logic [7:0] prog_wdata_in,
  input wire logic prog_wr_in,
  input wire logic prog_rd_in,
  output logic [7:0] prog_rdata_out,
  output logic prog_rvalid_out,
  input wire logic io_update_in,
  input wire logic [dcf_pkg::DCF_PROFILE_W-1:0] profile_select_pins_in,
  input wire logic [dcf_pkg::DCF_WORD_W-1:0] par_data_in,
  input wire logic [dcf_pkg::DCF_FUNC_W-1:0] function_select_pins_in,
  input wire logic ramp_enable_in,
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [dcf_pkg::DCF_WORD_W-1:0] word_data_out,
  output logic [dcf_pkg::DCF_FUNC_W-1:0] word_func_out,
  output logic par_ready_out,
  output logic sine_sel_out,
  output logic cal_start_out,
  output logic ramp_rate_load_out,
  output logic ramp_acc_reset_out,
  output logic phase_acc_reset_out
);
  import dcf_pkg::*;

  localparam int unsigned PIN_W = DCF_ADDR_W + 8 + 3 + DCF_PROFILE_W + DCF_WORD_W + DCF_FUNC_W;
  localparam int unsigned BUF_W = DCF_FUNC_W + DCF_WORD_W;

  // Two-stage synchroniser for every pin except ramp_enable_in and word_ready_in; only stage two is read by logic
  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {prog_addr_in, prog_wdata_in, prog_wr_in, prog_rd_in, io_update_in,
                    profile_select_pins_in, par_data_in, function_select_pins_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic [DCF_ADDR_W-1:0] addr_s;
  logic [7:0] wdata_s;
  logic wr_s;
  logic rd_s;
  logic upd_s;
  logic [DCF_PROFILE_W-1:0] prof_s;
  logic [DCF_WORD_W-1:0] data_s;
  logic [DCF_FUNC_W-1:0] func_s;

  assign {addr_s, wdata_s, wr_s, rd_s, upd_s, prof_s, data_s, func_s} = pin_s2_ff;

  // Previous levels for edge detection
  logic wr_prev_ff;
  logic rd_prev_ff;
  logic upd_prev_ff;
  logic [DCF_PROFILE_W-1:0] prof_prev_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
      upd_prev_ff <= 1'b0;
      prof_prev_ff <= '0;
    end else begin
      wr_prev_ff <= wr_s;
      rd_prev_ff <= rd_s;
      upd_prev_ff <= upd_s;
      prof_prev_ff <= prof_s;
    end
  end

  logic wr_rise;
  logic rd_rise;
  logic upd_rise;
  logic upd_event;
  logic addr_ok;
  logic ctrl1_hit;

  assign wr_rise = wr_s && !wr_prev_ff;
  assign rd_rise = rd_s && !rd_prev_ff;
  assign upd_rise = upd_s && !upd_prev_ff;
  // A profile pin change transfers the register like an update strobe, but takes no parallel word
  assign upd_event = upd_rise || (prof_s != prof_prev_ff);
  // Parallel byte address carries the serial index in its upper bits
  assign addr_ok = (addr_s <= DCF_PAR_LAST) && (addr_s[6:2] <= DCF_SERIAL_LAST);
  assign ctrl1_hit = addr_ok && (addr_s[6:2] == DCF_CTRL1_INDEX);

  // Buffered (written) and active copies of the control register
  logic [31:0] shadow_ff;
  logic [31:0] active_ff;
  logic [31:0] nxt_shadow;
  logic [31:0] nxt_active;

  always_comb begin
    nxt_shadow = shadow_ff;
    if (wr_rise && ctrl1_hit) begin
      unique case (addr_s[1:0])
        DCF_LANE_0: nxt_shadow[7:0] = wdata_s;
        DCF_LANE_1: nxt_shadow[15:8] = wdata_s;
        DCF_LANE_2: nxt_shadow[23:16] = wdata_s;
        DCF_LANE_3: nxt_shadow[31:24] = wdata_s;
      endcase
    end
    nxt_shadow = nxt_shadow & DCF_CTRL1_MASK;
  end

  // A write in the transfer cycle lands in the buffer; the old value goes active
  assign nxt_active = upd_event ? shadow_ff : active_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shadow_ff <= DCF_CTRL1_RESET;
    end else begin
      shadow_ff <= nxt_shadow;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_ff <= DCF_CTRL1_RESET;
    end else begin
      active_ff <= nxt_active;
    end
  end

  // Reads return the buffered value; other mapped bytes belong to other banks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_rdata_out <= 8'h00;
      prog_rvalid_out <= 1'b0;
    end else begin
      prog_rvalid_out <= rd_rise && addr_ok;
      if (rd_rise && ctrl1_hit) begin
        prog_rdata_out <= shadow_ff[{addr_s[1:0], 3'h0} +: 8];
      end else begin
        prog_rdata_out <= 8'h00;
      end
    end
  end

  // Waveform select and accumulator controls, aligned to the sync edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sine_sel_out <= DCF_CTRL1_RESET[DCF_BIT_SINE];
      ramp_acc_reset_out <= 1'b0;
      phase_acc_reset_out <= 1'b0;
    end else begin
      sine_sel_out <= nxt_active[DCF_BIT_SINE];
      ramp_acc_reset_out <= nxt_active[DCF_BIT_CLR_RAMP]
        || (upd_event && shadow_ff[DCF_BIT_AUTO_RAMP]);
      phase_acc_reset_out <= nxt_active[DCF_BIT_CLR_PHASE]
        || (upd_event && shadow_ff[DCF_BIT_AUTO_PHASE]);
    end
  end

  // Ramp rate reload only matters while the ramp generator runs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ramp_rate_load_out <= 1'b0;
    end else begin
      ramp_rate_load_out <= upd_event && ramp_enable_in && shadow_ff[DCF_BIT_LOAD_RATE];
    end
  end

  // Calibration fires on a 0 to 1 change only, so software must clear it first
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_start_out <= 1'b0;
    end else begin
      cal_start_out <= nxt_active[DCF_BIT_CAL] && !active_ff[DCF_BIT_CAL];
    end
  end

  // Parallel word path; pins cannot be stalled, so a full buffer drops the
  // sample and par_ready_out warns the source one cycle later
  logic buf_in_valid;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_out_data;

  assign buf_in_valid = active_ff[DCF_BIT_STREAM] ? 1'b1
    : upd_rise;

  dcf_skid_buf #(
    .WIDTH(BUF_W)
  ) u_word_buf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in({func_s, data_s}),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(buf_out_data)
  );

  assign {word_func_out, word_data_out} = buf_out_data;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      par_ready_out <= 1'b0;
    end else begin
      par_ready_out <= buf_in_ready;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_range_decode: assert property (
    prog_rvalid_out |-> $past(addr_ok) && $past(rd_rise)
  ) else $error("read answered for an unmapped address");

  a_hold_buffered: assert property (
    !upd_event |=> $stable(active_ff)
  ) else $error("active control changed without update");

  a_update_copy: assert property (
    upd_event |=> active_ff == $past(shadow_ff)
  ) else $error("update did not transfer buffered value");

  a_cal_once: assert property (
    cal_start_out |=> !cal_start_out
  ) else $error("calibration start longer than one cycle");

  a_cal_cause: assert property (
    $rose(active_ff[DCF_BIT_CAL]) |-> cal_start_out
  ) else $error("calibration not started on bit rise");

  a_manual_take: assert property (
    !active_ff[DCF_BIT_STREAM] && !upd_rise && !word_valid_out |=> !word_valid_out
  ) else $error("word taken without update in manual mode");

  a_stream_take: assert property (
    active_ff[DCF_BIT_STREAM] && buf_in_ready && (!word_valid_out || word_ready_in) |=>
      word_valid_out && word_data_out == $past(data_s) && word_func_out == $past(func_s)
  ) else $error("streaming mode skipped a sample");

  a_sine_stable: assert property (
    !upd_event |=> $stable(sine_sel_out)
  ) else $error("waveform select moved without update");

  a_rate_load: assert property (
    upd_event && ramp_enable_in && shadow_ff[DCF_BIT_LOAD_RATE] |=> ramp_rate_load_out
  ) else $error("ramp rate not reloaded on update");

  a_rate_quiet: assert property (
    !upd_event |=> !ramp_rate_load_out
  ) else $error("ramp rate reloaded without update");

  a_ramp_pulse: assert property (
    upd_event && shadow_ff[DCF_BIT_AUTO_RAMP] && !shadow_ff[DCF_BIT_CLR_RAMP]
      ##1 !upd_event |=> !ramp_acc_reset_out
  ) else $error("ramp accumulator auto reset not one cycle");

  a_phase_auto: assert property (
    upd_event && shadow_ff[DCF_BIT_AUTO_PHASE] |=> phase_acc_reset_out
  ) else $error("phase accumulator not cleared on update");

  a_ramp_hold: assert property (
    active_ff[DCF_BIT_CLR_RAMP] |-> ramp_acc_reset_out
  ) else $error("ramp accumulator released while clear set");

  a_phase_hold: assert property (
    active_ff[DCF_BIT_CLR_PHASE] |-> phase_acc_reset_out
  ) else $error("phase accumulator released while clear set");

  a_open_zero: assert property (
    (shadow_ff & ~DCF_CTRL1_MASK) == 32'h0000_0000
  ) else $error("open control bits hold a value");

endmodule // dcf_ctrl1
`default_nettype wire

// ===== dcf_host_model.sv
// Host controller model: byte-wide programming port, update, profile and data pins.
// Assumes tb_top calls its tasks from one process, one task at a time.
`timescale 1ns/1ns
`default_nettype none
module dcf_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic [6:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic upd_out,
  output logic [2:0] prof_out,
  output logic [31:0] par_out,
  output logic [3:0] fn_out
);
  initial begin
    addr_out = 7'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    upd_out = 1'b0;
    prof_out = 3'h0;
    par_out = 32'h0000_0000;
    fn_out = 4'h0;
  end

  // Address and data held one cycle before and four after the strobe
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b1;
    repeat (4) @(negedge clk_in);
    wr_out = 1'b0;
    // Released data must not keep its old value
    wdata_out = ~d;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic rd_byte(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'b1;
    v = 1'b0;
    d = 8'h00;
    repeat (8) begin
      @(negedge clk_in);
      if (rvalid_in === 1'b1) begin
        v = 1'b1;
        d = rdata_in;
      end
    end
    rd_out = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  // Update pin low long enough that each call with k low makes a fresh rising edge; k high steps the profile
  task automatic fire(input logic k);
    @(negedge clk_in);
    upd_out = 1'b0;
    repeat (3) @(negedge clk_in);
    if (k) prof_out = prof_out + 3'h1;
    else upd_out = 1'b1;
  endtask

  // Changed at the falling edge, so stable around every sync rising edge
  task automatic set_par(input logic [31:0] p, input logic [3:0] f);
    @(negedge clk_in);
    par_out = p;
    fn_out = f;
  endtask
endmodule // dcf_host_model
`default_nettype wire

// ===== dcf_pkg.sv
// Constants shared by the first control function register bank and its testbench.
// Assumes one clock, the sync clock, drives every block that imports it.
package dcf_pkg;

  // Programming space: serial register indices and parallel byte addresses
  localparam logic [4:0] DCF_SERIAL_LAST = 5'h1B;
  localparam logic [6:0] DCF_PAR_LAST = 7'h6F;
  localparam logic [4:0] DCF_CTRL1_INDEX = 5'h00;
  localparam int unsigned DCF_ADDR_W = 7;
  localparam int unsigned DCF_PROFILE_W = 3;
  localparam int unsigned DCF_FUNC_W = 4;
  localparam int unsigned DCF_WORD_W = 32;

  // Byte lanes of the control register in the parallel space
  localparam logic [1:0] DCF_LANE_0 = 2'h0;
  localparam logic [1:0] DCF_LANE_1 = 2'h1;
  localparam logic [1:0] DCF_LANE_2 = 2'h2;
  localparam logic [1:0] DCF_LANE_3 = 2'h3;

  // Field positions of the control register
  localparam int unsigned DCF_BIT_CAL = 24;
  localparam int unsigned DCF_BIT_STREAM = 17;
  localparam int unsigned DCF_BIT_SINE = 16;
  localparam int unsigned DCF_BIT_LOAD_RATE = 15;
  localparam int unsigned DCF_BIT_AUTO_RAMP = 14;
  localparam int unsigned DCF_BIT_AUTO_PHASE = 13;
  localparam int unsigned DCF_BIT_CLR_RAMP = 12;
  localparam int unsigned DCF_BIT_CLR_PHASE = 11;

  // Reset value and the mask of bits that hold storage
  localparam logic [31:0] DCF_CTRL1_RESET = 32'h0001_0000;
  localparam logic [31:0] DCF_CTRL1_MASK = 32'h0103_FBFF;

endpackage

// ===== dcf_skid_buf.sv
// Two-entry buffer with valid and ready on both sides; outputs come from flops.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module dcf_skid_buf #(
  parameter int unsigned WIDTH = 36
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  logic skid_valid_ff;
  logic [WIDTH-1:0] skid_data_ff;
  logic push;
  logic pop;

  // Ready is only dropped while the spare entry is occupied
  assign in_ready_out = !skid_valid_ff;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
      skid_valid_ff <= 1'b0;
      skid_data_ff <= '0;
    end else if (pop) begin
      if (skid_valid_ff) begin
        out_data_out <= skid_data_ff;
        skid_valid_ff <= 1'b0;
      end else if (push) begin
        out_data_out <= in_data_in;
      end else begin
        out_valid_out <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid_out) begin
        out_data_out <= in_data_in;
        out_valid_out <= 1'b1;
      end else begin
        skid_data_ff <= in_data_in;
        skid_valid_ff <= 1'b1;
      end
    end
  end

endmodule // dcf_skid_buf
`default_nettype wire

// ===== tb_top.sv
// Testbench for the first control function register bank.
// Assumes dcf_host_model drives every pin the host owns.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcf_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic word_ready_in = 1'b1;
  logic ramp_en = 1'b1;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, rvalid, upd_pin, v, wv, pr, sine, cal, load, rr, pz;
  logic [2:0] prof;
  logic [31:0] par, wd;
  logic [3:0] fn, wf;
  int err_total = 0;
  int compares = 0;
  int i;
  initial forever #50 clk_in = ~clk_in;
  dcf_host_model dcf_host_model_i (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .upd_out(upd_pin),
    .prof_out(prof), .par_out(par), .fn_out(fn));
  dcf_ctrl1 dcf_ctrl1_i (.clk_in(clk_in), .rst_in(rst_in), .prog_addr_in(addr),
    .prog_wdata_in(wdata), .prog_wr_in(wr), .prog_rd_in(rd), .prog_rdata_out(rdata),
    .prog_rvalid_out(rvalid), .io_update_in(upd_pin), .profile_select_pins_in(prof),
    .par_data_in(par), .function_select_pins_in(fn), .ramp_enable_in(ramp_en),
    .word_valid_out(wv), .word_ready_in(word_ready_in), .word_data_out(wd),
    .word_func_out(wf), .par_ready_out(pr), .sine_sel_out(sine), .cal_start_out(cal),
    .ramp_rate_load_out(load), .ramp_acc_reset_out(rr), .phase_acc_reset_out(pz));

  task automatic test_done();
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic rb(input logic [6:0] a, input logic [7:0] e, input logic ev);
    dcf_host_model_i.rd_byte(a, d, v);
    chk("rvalid", ev, v);
    if (ev) chk("rdata", e, d);
  endtask

  // Fires an event, counts pulses over ten cycles, then checks held levels
  task automatic upd(input logic k, input int ec, el, er, ep, input logic lr, lp);
    int c[4];
    c = '{default: 0};
    dcf_host_model_i.fire(k);
    repeat (10) begin
      @(negedge clk_in);
      c[0] += (cal === 1'b1);
      c[1] += (load === 1'b1);
      c[2] += (rr === 1'b1);
      c[3] += (pz === 1'b1);
    end
    chk("cal", ec, c[0]);
    chk("load", el, c[1]);
    if (er >= 0) chk("ramp", er, c[2]);
    if (ep >= 0) chk("phase", ep, c[3]);
    chk("ramp_lv", lr, rr);
    chk("phase_lv", lp, pz);
  endtask

  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    for (i = 0; i < 4; i++) rb(7'(i), DCF_CTRL1_RESET[8*i+:8], 1'b1);
    chk("sine", 1, sine);
    rb(7'h04, 8'h00, 1'b1);
    rb(7'h6F, 8'h00, 1'b1);
    rb(7'h70, 8'h00, 1'b0);
    for (i = 0; i < 4; i++) dcf_host_model_i.wr_byte(7'(i), 8'hFF);
    for (i = 0; i < 4; i++) rb(7'(i), DCF_CTRL1_MASK[8*i+:8], 1'b1);
    dcf_host_model_i.wr_byte(7'h02, 8'h00);
    chk("sine", 1, sine);
    upd(1'b0, 1, 1, -1, -1, 1'b1, 1'b1);
    chk("sine", 0, sine);
    upd(1'b0, 0, 1, -1, -1, 1'b1, 1'b1);
    dcf_host_model_i.wr_byte(7'h03, 8'h00);
    dcf_host_model_i.wr_byte(7'h01, 8'h00);
    upd(1'b1, 0, 0, -1, -1, 1'b0, 1'b0);
    dcf_host_model_i.wr_byte(7'h03, 8'h01);
    dcf_host_model_i.wr_byte(7'h01, 8'h60);
    upd(1'b1, 1, 0, 1, 1, 1'b0, 1'b0);
    upd(1'b0, 0, 0, 1, 1, 1'b0, 1'b0);
    dcf_host_model_i.wr_byte(7'h01, 8'h80);
    word_ready_in = 1'b0;
    dcf_host_model_i.set_par(32'hA5A5_0001, 4'h3);
    upd(1'b0, 0, 1, 0, 0, 1'b0, 1'b0);
    chk("wvalid", 1, wv);
    chk("wdata", 32'hA5A5_0001, wd);
    chk("wfunc", 4'h3, wf);
    dcf_host_model_i.set_par(32'h5A5A_0002, 4'h5);
    upd(1'b1, 0, 1, 0, 0, 1'b0, 1'b0);
    word_ready_in = 1'b1;
    @(negedge clk_in);
    word_ready_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("wvalid", 0, wv);
    // Reload must stay quiet while the ramp generator is off
    ramp_en = 1'b0;
    upd(1'b1, 0, 0, 0, 0, 1'b0, 1'b0);
    ramp_en = 1'b1;
    dcf_host_model_i.wr_byte(7'h01, 8'h00);
    dcf_host_model_i.wr_byte(7'h02, 8'h02);
    word_ready_in = 1'b1;
    upd(1'b0, 0, 0, 0, 0, 1'b0, 1'b0);
    dcf_host_model_i.set_par(32'h1234_ABCD, 4'h9);
    repeat (5) @(negedge clk_in);
    word_ready_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("par_ready", 0, pr);
    chk("wdata", 32'h1234_ABCD, wd);
    dcf_host_model_i.set_par(32'hCAFE_0003, 4'h1);
    repeat (4) @(negedge clk_in);
    word_ready_in = 1'b1;
    @(negedge clk_in);
    word_ready_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("wdata", 32'h1234_ABCD, wd);
    word_ready_in = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("wdata", 32'hCAFE_0003, wd);
    chk("wfunc", 4'h1, wf);
    chk("par_ready", 1, pr);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("sine", 1, sine);
    rb(7'h02, DCF_CTRL1_RESET[23:16], 1'b1);
    test_done();
  end

  initial begin
    repeat (20000) @(negedge clk_in);
    err_total++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
